// ---- air_pkg.sv ----
// shared constants, register map and carrier types of the input router
package air_pkg;
    localparam int TRACKS = 64;
    localparam int ANALOG_CH = 8;
    localparam int AES_CH = 8;
    localparam int MADI_CH = 64;
    localparam int NET_CH = 64;
    localparam int SW = 24;
    ////////////////////////////////////////////////////////////////////////
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int SECOND_S = 1;
    localparam int RATE_HZ [4] = '{44100, 48000, 88200, 96000};
    localparam int AES_RATE_MIN_HZ = 32000;
    localparam int AES_RATE_MAX_HZ = 192000;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [3:0] REGION_SYS = 4'h0;
    localparam logic [3:0] REGION_SOURCE = 4'h1;
    localparam logic [3:0] REGION_GAIN = 4'h2;
    localparam logic [3:0] REGION_DELAY = 4'h3;
    localparam logic [3:0] REGION_PEAK = 4'h4;
    localparam logic [3:0] REGION_AGAIN = 4'h5;
    localparam int CTRL_SYNC_INT = 0;
    localparam int CTRL_RATE_LSB = 1;
    localparam int CTRL_CONN_LSB = 4;
    localparam int CTRL_GLINK = 6;
    localparam int CTRL_DLINK = 7;
    localparam int CTRL_REDUND = 8;
    localparam int CTRL_HOLD_LSB = 9;
    localparam logic [11:0] CTRL_RESET = 12'h223;
    localparam int SRC_KIND_LSB = 0;
    localparam int SRC_INDEX_LSB = 8;
    ////////////////////////////////////////////////////////////////////////
    localparam int GAIN_MIN_DB = -25;
    localparam int GAIN_MAX_LOW_DB = 20;
    localparam int GAIN_MAX_HIGH_DB = 50;
    localparam logic [7:0] GAIN_OFF = 8'h80;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam int DELAY_MAX_MS = 400;
    localparam int HOLD_MAX_S = 5;
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        SRC_OFF = 3'h0,
        SRC_ANALOG = 3'h1,
        SRC_AES = 3'h2,
        SRC_MADI = 3'h3,
        SRC_NET = 3'h4
    } air_src_type;
    typedef enum logic [1:0] {
        CONN_COAX = 2'h0,
        CONN_OPT = 2'h1,
        CONN_AUTO = 2'h2
    } air_conn_type;
    typedef struct packed {
        logic [5:0] index;
        air_src_type kind;
    } air_route_type;
    typedef struct packed {
        logic valid;
        logic [5:0] track;
        logic [SW-1:0] sample;
    } air_track_out_type;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } air_apb_req_type;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } air_apb_rsp_type;
endpackage

// ---- air_input_router.sv ----
// per-track source router with gain, delay line and peak-hold metering
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module air_input_router #(
    parameter int DEPTH_W = 16,
    parameter int SECOND_CYCLES = air_pkg::SECOND_S * air_pkg::CLK_HZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire air_pkg::air_apb_req_type apbReq,
    output air_pkg::air_apb_rsp_type apbRsp,
    input wire logic [7:0][23:0] analogMulti,
    input wire logic [1:0][23:0] analogXlr,
    input wire logic [7:0][23:0] aesData,
    input wire logic [7:0] aesStrobe,
    input wire logic [63:0][23:0] madiCoaxData,
    input wire logic [63:0] madiCoaxPresent,
    input wire logic [63:0][23:0] madiOptData,
    input wire logic [63:0] madiOptPresent,
    input wire logic madiStrobe,
    input wire logic [63:0][23:0] netData,
    input wire logic [63:0] netConnected,
    input wire logic netStrobe,
    input wire logic extRefTick,
    input wire logic [1:0] extRateCode,
    output air_pkg::air_track_out_type trackOut,
    output logic netPrimaryEn,
    output logic netSecondaryEn
);
    typedef struct packed {
        logic [11:0] ctrl;
        air_pkg::air_route_type [63:0] route;
        logic [63:0][7:0] gain;
        logic [7:0][7:0] again;
        logic [63:0][8:0] delayMs;
        logic [63:0][22:0] peak;
        logic [63:0][2:0] hold;
        logic [7:0][23:0] aesHold;
        logic [63:0][23:0] madiHold;
        logic [63:0][23:0] netHold;
        logic [7:0] divCnt;
        logic [31:0] secCnt;
        logic [6:0] trackCnt;
        logic [DEPTH_W-1:0] wrPtr;
        logic bValid;
        logic [5:0] bTrack;
        logic [23:0] bSample;
        logic bBypass;
        air_pkg::air_track_out_type out;
        air_pkg::air_apb_rsp_type apb;
        logic netPri;
        logic netSec;
    } air_state_type;

    air_state_type st;
    air_state_type next_st;
    logic [23:0] mem [air_pkg::TRACKS * (2 ** DEPTH_W)];
    logic [23:0] ramQ;
    logic ramWe;
    logic [DEPTH_W+5:0] ramWa;
    logic [DEPTH_W+5:0] ramRa;
    logic [23:0] ramWd;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] satAdd(logic [23:0] a, logic [23:0] b);
        int s;
        s = int'(signed'(a)) + int'(signed'(b));
        if (s > 32'sh7FFFFF) begin
            return 24'h7FFFFF;
        end
        if (s < -32'sh800000) begin
            return 24'h800000;
        end
        return s[23:0];
    endfunction

    function automatic logic [7:0] clampGain(int v, int hi);
        if (v < air_pkg::GAIN_MIN_DB) begin
            return 8'(air_pkg::GAIN_MIN_DB);
        end
        if (v > hi) begin
            return 8'(hi);
        end
        return 8'(v);
    endfunction

    function automatic int gainHigh(air_pkg::air_src_type k);
        if (k == air_pkg::SRC_AES || k == air_pkg::SRC_MADI) begin
            return air_pkg::GAIN_MAX_HIGH_DB;
        end
        return air_pkg::GAIN_MAX_LOW_DB;
    endfunction

    // 2^(dB/6) with a 1 dB fine table in 1.15 form
    function automatic logic [23:0] applyGain(logic [23:0] s, logic [7:0] g,
                                              int hi);
        logic signed [55:0] p;
        logic [16:0] m;
        int e;
        int q;
        if (g == air_pkg::GAIN_OFF) begin
            return 24'h000000;
        end
        e = int'(signed'(g));
        if (e > hi) begin
            e = hi;
        end
        e = e + 30;
        q = e / 6;
        unique case (e % 6)
            0: m = 17'h08000;
            1: m = 17'h08FAD;
            2: m = 17'h0A145;
            3: m = 17'h0B505;
            4: m = 17'h0CB30;
            default: m = 17'h0E412;
        endcase
        p = 56'(signed'(s)) * 56'(signed'({1'b0, m}));
        p = (p <<< q) >>> 20;
        if (p > 56'sh7FFFFF) begin
            return 24'h7FFFFF;
        end
        if (p < -56'sh800000) begin
            return 24'h800000;
        end
        return p[23:0];
    endfunction

    function automatic logic [22:0] magnitude(logic [23:0] s);
        logic [23:0] n;
        n = 24'h000000 - s;
        if (s == 24'h800000) begin
            return 23'h7FFFFF;
        end
        return s[23] ? n[22:0] : s[22:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        int t;
        int hi;
        int v;
        int delta;
        logic [1:0] rateCode;
        logic frameTick;
        logic secTick;
        logic [7:0] div;
        logic [23:0] src;
        logic [7:0] g;
        logic [23:0] gained;
        logic [22:0] dSamp;
        logic [23:0] outS;
        logic [22:0] mag;
        air_pkg::air_route_type r;
        logic [3:0] region;
        logic [5:0] idx;
        logic mapped;
        logic legal;
        logic [31:0] rd;
        logic [31:0] wd;
        logic [2:0] holdSet;
        t = 0;
        hi = 0;
        v = 0;
        delta = 0;
        src = 24'h000000;
        g = 8'h00;
        gained = 24'h000000;
        dSamp = 23'h0;
        r = '0;
        next_st = st;
        next_st.apb.pready = 1'b0;
        next_st.apb.pslverr = 1'b0;
        ramWe = 1'b0;
        ramWa = '0;
        ramRa = '0;
        ramWd = 24'h000000;
        holdSet = st.ctrl[air_pkg::CTRL_HOLD_LSB +: 3];
        // working rate from setting or reference
        rateCode = st.ctrl[air_pkg::CTRL_SYNC_INT] ?
                   st.ctrl[air_pkg::CTRL_RATE_LSB +: 2] : extRateCode;
        div = 8'(air_pkg::CLK_HZ / air_pkg::RATE_HZ[rateCode]);
        secTick = (st.secCnt == 32'(SECOND_CYCLES - 1));
        next_st.secCnt = secTick ? 32'h00000000 : st.secCnt + 32'h00000001;
        if (st.ctrl[air_pkg::CTRL_SYNC_INT]) begin
            frameTick = (st.divCnt >= div - 8'h01);
            next_st.divCnt = frameTick ? 8'h00 : st.divCnt + 8'h01;
        end else begin
            frameTick = extRefTick;
            next_st.divCnt = 8'h00;
        end
        next_st.netPri = 1'b1;
        next_st.netSec = st.ctrl[air_pkg::CTRL_REDUND];
        // digital inputs held at their own rate, read at the working rate
        for (int i = 0; i < air_pkg::AES_CH; i++) begin
            if (aesStrobe[i]) begin
                next_st.aesHold[i] = aesData[i];
            end
        end
        for (int i = 0; i < air_pkg::MADI_CH; i++) begin
            if (madiStrobe) begin
                unique case (st.ctrl[air_pkg::CTRL_CONN_LSB +: 2])
                    air_pkg::CONN_COAX: next_st.madiHold[i] = madiCoaxData[i];
                    air_pkg::CONN_OPT: next_st.madiHold[i] = madiOptData[i];
                    default: begin
                        if (madiOptPresent[i]) begin
                            next_st.madiHold[i] = madiOptData[i];
                        end else if (madiCoaxPresent[i]) begin
                            next_st.madiHold[i] = madiCoaxData[i];
                        end else begin
                            next_st.madiHold[i] = 24'h000000;
                        end
                    end
                endcase
            end
        end
        for (int i = 0; i < air_pkg::NET_CH; i++) begin
            if (netStrobe) begin
                next_st.netHold[i] = netConnected[i] ? netData[i] : 24'h0;
            end
        end
        ////////////////////////////////////////////////////////////////////
        // stage A: one track per cycle after each frame tick
        if (frameTick && st.trackCnt[6]) begin
            next_st.trackCnt = 7'h00;
        end
        next_st.bValid = 1'b0;
        if (!st.trackCnt[6]) begin
            t = int'(st.trackCnt[5:0]);
            r = st.route[t];
            unique case (r.kind)
                air_pkg::SRC_ANALOG: begin
                    src = analogMulti[r.index[2:0]];
                    if (r.index < 6'h02) begin
                        src = satAdd(src, analogXlr[r.index[0]]);
                    end
                end
                air_pkg::SRC_AES: src = st.aesHold[r.index[2:0]];
                air_pkg::SRC_MADI: src = st.madiHold[r.index];
                air_pkg::SRC_NET: src = st.netHold[r.index];
                default: src = 24'h000000;
            endcase
            g = (r.kind == air_pkg::SRC_ANALOG) ?
                st.again[r.index[2:0]] : st.gain[t];
            gained = applyGain(src, g, gainHigh(r.kind));
            dSamp = 23'(st.delayMs[t] *
                    (air_pkg::RATE_HZ[rateCode] / air_pkg::MS_PER_S));
            if (dSamp > 23'(2 ** DEPTH_W - 1)) begin
                dSamp = 23'(2 ** DEPTH_W - 1);
            end
            ramWe = 1'b1;
            ramWa = {st.trackCnt[5:0], st.wrPtr};
            ramRa = {st.trackCnt[5:0], st.wrPtr - dSamp[DEPTH_W-1:0]};
            ramWd = gained;
            next_st.bValid = 1'b1;
            next_st.bTrack = st.trackCnt[5:0];
            next_st.bSample = gained;
            next_st.bBypass = (dSamp == 23'h0);
            next_st.trackCnt = st.trackCnt + 7'h01;
            if (st.trackCnt == 7'h3F) begin
                next_st.wrPtr = st.wrPtr + 1'b1;
            end
        end
        ////////////////////////////////////////////////////////////////////
        // stage B: delayed sample out and metering
        outS = st.bBypass ? st.bSample : ramQ;
        mag = magnitude(outS);
        next_st.out.valid = st.bValid;
        if (st.bValid) begin
            next_st.out.track = st.bTrack;
            next_st.out.sample = outS;
        end
        for (int i = 0; i < air_pkg::TRACKS; i++) begin
            if (st.bValid && st.bTrack == 6'(i) &&
                (holdSet == 3'h0 || mag >= st.peak[i])) begin
                next_st.peak[i] = mag;
                next_st.hold[i] = holdSet;
            end else if (secTick && st.hold[i] != 3'h0) begin
                next_st.hold[i] = st.hold[i] - 3'h1;
                if (st.hold[i] == 3'h1) begin
                    next_st.peak[i] = 23'h0;
                end
            end
        end
        ////////////////////////////////////////////////////////////////////
        // APB slave: read data latched in setup, write data taken and answer given in the first access cycle
        region = apbReq.paddr[11:8];
        idx = apbReq.paddr[7:2];
        wd = apbReq.pwdata;
        r.kind = air_pkg::air_src_type'(wd[air_pkg::SRC_KIND_LSB +: 3]);
        r.index = wd[air_pkg::SRC_INDEX_LSB +: 6];
        unique case (region)
            air_pkg::REGION_SYS: mapped = (idx < 6'h02);
            air_pkg::REGION_AGAIN: mapped = (idx < 6'h08);
            air_pkg::REGION_SOURCE, air_pkg::REGION_GAIN,
            air_pkg::REGION_DELAY, air_pkg::REGION_PEAK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        legal = mapped;
        if (region == air_pkg::REGION_SOURCE && apbReq.pwrite) begin
            unique case (r.kind)
                air_pkg::SRC_OFF, air_pkg::SRC_MADI: legal = mapped;
                air_pkg::SRC_ANALOG, air_pkg::SRC_AES: legal = r.index < 6'h08;
                air_pkg::SRC_NET: legal = netConnected[r.index];
                default: legal = 1'b0;
            endcase
        end
        unique case (region)
            air_pkg::REGION_SYS: rd = (idx == 6'h00) ? 32'(st.ctrl) :
                                 32'({st.trackCnt[6], rateCode});
            air_pkg::REGION_SOURCE: rd = 32'({st.route[idx].index, 5'h00,
                                              st.route[idx].kind});
            // an analog-fed track shows the shared channel gain
            air_pkg::REGION_GAIN: rd = (st.route[idx].kind ==
                air_pkg::SRC_ANALOG) ?
                32'(st.again[st.route[idx].index[2:0]]) :
                32'(st.gain[idx]);
            air_pkg::REGION_DELAY: rd = 32'(st.delayMs[idx]);
            air_pkg::REGION_PEAK: rd = 32'(st.peak[idx]);
            air_pkg::REGION_AGAIN: rd = 32'(st.again[idx[2:0]]);
            default: rd = 32'h00000000;
        endcase
        if (apbReq.psel && !apbReq.penable) begin
            next_st.apb.pready = 1'b1;
            next_st.apb.pslverr = !legal;
            next_st.apb.prdata = legal ? rd : 32'h00000000;
        end
        if (apbReq.psel && apbReq.penable && st.apb.pready &&
            apbReq.pwrite && legal) begin
            unique case (region)
                air_pkg::REGION_SYS: begin
                    if (idx == 6'h00) begin
                        next_st.ctrl = wd[11:0];
                        if (wd[air_pkg::CTRL_HOLD_LSB +: 3] >
                            3'(air_pkg::HOLD_MAX_S)) begin
                            next_st.ctrl[air_pkg::CTRL_HOLD_LSB +: 3] =
                                3'(air_pkg::HOLD_MAX_S);
                        end
                    end
                end
                air_pkg::REGION_SOURCE: next_st.route[idx] = r;
                air_pkg::REGION_GAIN, air_pkg::REGION_AGAIN: begin
                    if (region == air_pkg::REGION_AGAIN) begin
                        g = st.again[idx[2:0]];
                        hi = air_pkg::GAIN_MAX_LOW_DB;
                    end else if (st.route[idx].kind == air_pkg::SRC_ANALOG) begin
                        g = st.again[st.route[idx].index[2:0]];
                        hi = air_pkg::GAIN_MAX_LOW_DB;
                    end else begin
                        g = st.gain[idx];
                        hi = gainHigh(st.route[idx].kind);
                    end
                    if (wd[7:0] == air_pkg::GAIN_OFF) begin
                        v = 0;
                    end else begin
                        v = int'(signed'(clampGain(int'(signed'(wd[7:0])),
                                                   hi)));
                    end
                    if (st.ctrl[air_pkg::CTRL_GLINK] &&
                        wd[7:0] != air_pkg::GAIN_OFF &&
                        g != air_pkg::GAIN_OFF) begin
                        delta = v - int'(signed'(g));
                        for (int i = 0; i < air_pkg::TRACKS; i++) begin
                            if (st.gain[i] != air_pkg::GAIN_OFF) begin
                                next_st.gain[i] = clampGain(
                                    int'(signed'(st.gain[i])) + delta,
                                    air_pkg::GAIN_MAX_HIGH_DB);
                            end
                        end
                        for (int i = 0; i < air_pkg::ANALOG_CH; i++) begin
                            if (st.again[i] != air_pkg::GAIN_OFF) begin
                                next_st.again[i] = clampGain(
                                    int'(signed'(st.again[i])) + delta,
                                    air_pkg::GAIN_MAX_LOW_DB);
                            end
                        end
                    end else begin
                        g = (wd[7:0] == air_pkg::GAIN_OFF) ?
                            air_pkg::GAIN_OFF : 8'(v);
                        if (region == air_pkg::REGION_AGAIN) begin
                            next_st.again[idx[2:0]] = g;
                        end else if (st.route[idx].kind ==
                                     air_pkg::SRC_ANALOG) begin
                            next_st.again[st.route[idx].index[2:0]] = g;
                        end else begin
                            next_st.gain[idx] = g;
                        end
                    end
                end
                air_pkg::REGION_DELAY: begin
                    v = (wd[15:0] > 16'(air_pkg::DELAY_MAX_MS)) ?
                        air_pkg::DELAY_MAX_MS : int'(wd[15:0]);
                    if (st.ctrl[air_pkg::CTRL_DLINK]) begin
                        delta = v - int'(st.delayMs[idx]);
                        for (int i = 0; i < air_pkg::TRACKS; i++) begin
                            v = int'(st.delayMs[i]) + delta;
                            if (v < 0) begin
                                v = 0;
                            end
                            if (v > air_pkg::DELAY_MAX_MS) begin
                                v = air_pkg::DELAY_MAX_MS;
                            end
                            next_st.delayMs[i] = 9'(v);
                        end
                    end else begin
                        next_st.delayMs[idx] = 9'(v);
                    end
                end
                default: begin
                end
            endcase
        end
        if (rst) begin
            next_st = '0;
            next_st.ctrl = air_pkg::CTRL_RESET;
            next_st.trackCnt = 7'h40;
            next_st.apb.pready = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    // per-track delay store, read-before-write
    always_ff @(posedge clk_sys) begin
        if (ramWe) begin
            mem[ramWa] <= ramWd;
        end
        ramQ <= mem[ramRa];
    end

    assign apbRsp = st.apb;
    assign trackOut = st.out;
    assign netPrimaryEn = st.netPri;
    assign netSecondaryEn = st.netSec;
endmodule

// ---- air_checker.sv ----
// port assertions for the per-track input router
`timescale 1ns/1ps
module air_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire air_pkg::air_apb_req_type apbReq,
    input wire air_pkg::air_apb_rsp_type apbRsp,
    input wire air_pkg::air_track_out_type trackOut,
    input wire logic netPrimaryEn,
    input wire logic netSecondaryEn
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_setup;
        apbReq.psel && !apbReq.penable;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> apbRsp.pready)
        else $error("no ready after setup");
    a_ready_single: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("ready longer than one cycle");
    a_no_stray_ready: assert property (!apbReq.psel |=> !apbRsp.pready)
        else $error("ready without request");
    a_err_with_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("error without ready");
    a_unmapped_err: assert property (
        s_setup ##0 apbReq.paddr[11:8] > 4'h5 |=> apbRsp.pslverr)
        else $error("unmapped access not refused");
    a_burst_start: assert property ($rose(trackOut.valid) |->
        trackOut.track == 6'h00 ##1 trackOut.valid [*7])
        else $error("frame does not start at track zero");
    a_burst_step: assert property (trackOut.valid &&
        trackOut.track != 6'h3F |=> trackOut.valid &&
        trackOut.track == $past(trackOut.track) + 6'h01)
        else $error("tracks not consecutive");
    a_burst_end: assert property (
        $fell(trackOut.valid) |-> $past(trackOut.track) == 6'h3F)
        else $error("frame ended early");
    a_primary_on: assert property (!$past(rst) && !$past(rst, 2) &&
        !$past(rst, 3) |-> netPrimaryEn)
        else $error("primary port not enabled");
endmodule
bind air_input_router air_checker air_checker_inst (.clk_sys, .rst,
    .apbReq, .apbRsp, .trackOut, .netPrimaryEn, .netSecondaryEn);

// ---- air_source_model.sv ----
// behavioural model of the external audio sources
`timescale 1ns/1ps
module air_source_model (
    input wire logic clk_sys,
    input wire logic coaxOn,
    input wire logic optOn,
    input wire logic netOn,
    output logic [7:0][23:0] analogMulti,
    output logic [1:0][23:0] analogXlr,
    output logic [7:0][23:0] aesData,
    output logic [7:0] aesStrobe,
    output logic [63:0][23:0] madiCoaxData,
    output logic [63:0] madiCoaxPresent,
    output logic [63:0][23:0] madiOptData,
    output logic [63:0] madiOptPresent,
    output logic madiStrobe,
    output logic [63:0][23:0] netData,
    output logic [63:0] netConnected,
    output logic netStrobe
);
    logic [7:0] cnt = 8'h00;
    always_ff @(posedge clk_sys) begin
        cnt <= cnt + 8'h01;
    end
    // each channel carries a fixed word naming its source and index
    always_comb begin
        for (int i = 0; i < 64; i++) begin
            madiCoaxData[i] = 24'h100000 + 24'(i);
            madiOptData[i] = 24'h200000 + 24'(i);
            netData[i] = 24'h300000 + 24'(i);
            if (i < 8) begin
                analogMulti[i] = 24'h010000 + 24'(i);
                aesData[i] = 24'h400000 + 24'(i);
            end
        end
    end
    assign analogXlr = {24'h000200, 24'h000100};
    assign madiCoaxPresent = {64{coaxOn}};
    assign madiOptPresent = {64{optOn}};
    assign netConnected = {64{netOn}};
    assign madiStrobe = (cnt == 8'h00);
    assign netStrobe = (cnt == 8'h00);
    assign aesStrobe = {8{cnt == 8'h00}};
endmodule

// ---- test_audio_input_router_gain_delay.sv ----
// self-checking bench for the per-track input router
`timescale 1ns/1ps
module test_audio_input_router_gain_delay;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    air_pkg::air_apb_req_type apbReq = '0;
    air_pkg::air_apb_rsp_type apbRsp;
    air_pkg::air_track_out_type trackOut;
    logic [7:0][23:0] analogMulti, aesData;
    logic [1:0][23:0] analogXlr;
    logic [63:0][23:0] madiCoaxData, madiOptData, netData;
    logic [63:0] madiCoaxPresent, madiOptPresent, netConnected;
    logic [7:0] aesStrobe;
    logic madiStrobe, netStrobe, netPrimaryEn, netSecondaryEn;
    logic coaxOn = 1'b1, optOn = 1'b1, netOn = 1'b0;
    logic extRefTick = 1'b0;
    logic [1:0] extRateCode = 2'h1;
    logic [31:0] rd;
    logic [23:0] smp;
    logic err;
    int fails = 0;
    int n_compared = 0;
    always #50 clk_sys = ~clk_sys;
    air_input_router #(.DEPTH_W(8), .SECOND_CYCLES(50)) air_input_router_inst (
        .clk_sys, .rst, .apbReq, .apbRsp, .analogMulti, .analogXlr, .aesData,
        .aesStrobe, .madiCoaxData, .madiCoaxPresent, .madiOptData,
        .madiOptPresent, .madiStrobe, .netData, .netConnected, .netStrobe,
        .extRefTick, .extRateCode, .trackOut, .netPrimaryEn, .netSecondaryEn);
    air_source_model air_source_model_inst (.clk_sys, .coaxOn, .optOn, .netOn,
        .analogMulti, .analogXlr, .aesData, .aesStrobe, .madiCoaxData,
        .madiCoaxPresent, .madiOptData, .madiOptPresent, .madiStrobe,
        .netData, .netConnected, .netStrobe);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        apbReq <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask
    // skips two frames so that the input holds have caught up
    task automatic sample_of(input logic [5:0] t);
        repeat (3) begin
            for (int k = 0; k < 600; k++) begin
                @(posedge clk_sys);
                if (trackOut.valid === 1'b1 && trackOut.track === t) break;
            end
        end
        smp = trackOut.sample;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_source;
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl", rd, 32'h223);
        apb(1'b0, 12'h600, 32'h0);
        apb(1'b1, 12'h108, 32'h304);
        check("err", {31'h0, err}, 32'h1);
        netOn <= 1'b1;
        apb(1'b1, 12'h108, 32'h304);
        check("err", {31'h0, err}, 32'h0);
        apb(1'b0, 12'h108, 32'h0);
        check("source", rd, 32'h304);
    endtask
    task automatic t_audio;
        apb(1'b1, 12'h100, 32'h1);
        apb(1'b1, 12'h104, 32'h503);
        sample_of(6'h00);
        check("analog", {8'h0, smp}, 32'h010100);
        sample_of(6'h02);
        check("net", {8'h0, smp}, 32'h300003);
        sample_of(6'h01);
        check("madi", {8'h0, smp}, 32'h200005);
        optOn <= 1'b0;
        sample_of(6'h01);
        check("madi", {8'h0, smp}, 32'h100005);
    endtask
    task automatic t_gain;
        apb(1'b1, 12'h200, 32'h32);
        apb(1'b0, 12'h500, 32'h0);
        check("shared", rd, 32'h14);
        apb(1'b1, 12'h204, 32'h3C);
        apb(1'b0, 12'h204, 32'h0);
        check("gain", rd, 32'h32);
        apb(1'b1, 12'h208, 32'h3C);
        apb(1'b0, 12'h208, 32'h0);
        check("gain", rd, 32'h14);
        apb(1'b1, 12'h200, 32'hE0);
        apb(1'b0, 12'h200, 32'h0);
        check("gain", rd, 32'hE7);
    endtask
    task automatic t_link;
        apb(1'b1, 12'h000, 32'h2E3);
        apb(1'b1, 12'h204, 32'h28);
        apb(1'b0, 12'h208, 32'h0);
        check("linked gain", rd, 32'h0A);
        apb(1'b1, 12'h30C, 32'h1F4);
        apb(1'b0, 12'h30C, 32'h0);
        check("delay", rd, 32'h190);
        apb(1'b0, 12'h310, 32'h0);
        check("linked delay", rd, 32'h190);
        apb(1'b1, 12'h000, 32'hFE3);
        apb(1'b0, 12'h000, 32'h0);
        check("hold", rd, 32'hBE3);
        check("secondary", {31'h0, netSecondaryEn}, 32'h1);
    endtask
    task automatic summarize;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_source;
        t_audio;
        t_gain;
        t_link;
        summarize;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        summarize;
    end
endmodule
